// >>> hw/css_cfg.svh
// constants for the configuration start-up pin sequencer
`ifndef CSS_CFG_SVH
`define CSS_CFG_SVH

`define CSS_CLK_PERIOD_NS   10
`define CSS_CLEAR_TIME_NS   640
`define CSS_CLEAR_CYCLES    (`CSS_CLEAR_TIME_NS / `CSS_CLK_PERIOD_NS)

`define CSS_REG_CTRL        8'h00
`define CSS_REG_STATUS      8'h04

`define CSS_CTRL_DONE_BIT   0
`define CSS_CTRL_TERM_LSB   1
`define CSS_CTRL_TERM_MSB   2
`define CSS_TERM_RESET      2'h1

`define CSS_STAT_STATE_LSB  0
`define CSS_STAT_STATE_MSB  2
`define CSS_STAT_MODE_LSB   3
`define CSS_STAT_MODE_MSB   5
`define CSS_STAT_INIT_BIT   6
`define CSS_STAT_POWER_BIT  7
`define CSS_STAT_TERM_LSB   8
`define CSS_STAT_TERM_MSB   9

`define CSS_MODE_RESET      3'h0
`define CSS_MODE_NO_DUAL    3'h7
`define CSS_DUAL_USED_NONE  8'h00
`define CSS_DUAL_USED_SER   8'h03
`define CSS_DUAL_USED_PAR   8'hFF
`define CSS_READ_ZERO       32'h0

`endif

// >>> hw/css_pkg.sv
// types for the configuration start-up pin sequencer
package css_pkg;

   typedef enum logic [2:0] {
      CSS_POR     = 3'h0,
      CSS_CLEAR   = 3'h1,
      CSS_CONFIG  = 3'h3,
      CSS_STARTUP = 3'h2,
      CSS_USER    = 3'h6
   } css_state_t;

   typedef enum logic [1:0] {
      CSS_TERM_FLOAT    = 2'h0,
      CSS_TERM_PULLDOWN = 2'h1,
      CSS_TERM_PULLUP   = 2'h2
   } css_term_t;

endpackage : css_pkg

// >>> hw/css_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module css_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             sys_clk_in,
   input  wire logic             reset_in,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   generate
      for (genvar i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge sys_clk_in) begin
            if (reset_in) begin
               stage1[i]   <= 1'b0;
               sync_out[i] <= 1'b0;
            end else begin
               stage1[i]   <= async_in[i];
               sync_out[i] <= stage1[i];
            end
         end
      end
   endgenerate
endmodule : css_sync

// >>> hw/css_sequencer.sv
// power-on, configuration and start-up sequencing of pins and global nets
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "css_cfg.svh"
module css_sequencer
   import css_pkg::*;
(
   input  wire logic        sys_clk_in,
   input  wire logic        reset_in,
   input  wire logic        core_supply_good_in,
   input  wire logic        auxiliary_supply_good_in,
   input  wire logic        bank_output_supply_good_in,
   input  wire logic        config_pullup_select_n_in,
   input  wire logic        config_mode_sel_0_in,
   input  wire logic        config_mode_sel_1_in,
   input  wire logic        config_mode_sel_2_in,
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [31:0] reg_wdata_in,
   input  wire logic        reg_write_in,
   input  wire logic        reg_read_in,
   output logic      [31:0] reg_rdata_out,
   output logic             global_set_reset_net_out,
   output logic             global_three_state_net_out,
   output logic             global_write_enable_net_out,
   output logic             init_ready_n_out,
   output logic      [2:0]  config_mode_out,
   output logic             user_drivers_enable_out,
   output logic             pullup_enable_out,
   output logic      [7:0]  dual_pullup_enable_out,
   output logic             select_pin_weak_pullup_out,
   output logic             select_pin_as_gpio_out,
   output logic             select_pin_gpio_value_out,
   output logic      [1:0]  unused_pad_termination_out,
   output logic             user_mode_out
);
   localparam logic [7:0] CLEAR_LAST = 8'((`CSS_CLEAR_CYCLES) - 1);

   logic [6:0]  pins_async;
   logic [6:0]  pins_sync;
   logic        supplies_ok;
   logic        select_n;
   logic [2:0]  mode_sync;
   css_state_t  state;
   css_state_t  next_state;
   logic [7:0]  clear_count;
   logic        config_done;
   css_term_t   term_setting;
   logic        in_config;

   // dual-purpose pins that the selected mode drives itself
   function automatic logic [7:0] dual_used(input logic [2:0] mode);
      if (mode == `CSS_MODE_NO_DUAL) begin
         return `CSS_DUAL_USED_NONE;
      end else if (mode[1]) begin
         return `CSS_DUAL_USED_PAR;
      end else begin
         return `CSS_DUAL_USED_SER;
      end
   endfunction : dual_used

   assign pins_async = {config_mode_sel_2_in, config_mode_sel_1_in, config_mode_sel_0_in,
                        config_pullup_select_n_in, bank_output_supply_good_in,
                        auxiliary_supply_good_in, core_supply_good_in};

   css_sync #(.WIDTH(7)) u_sync (
      .sys_clk_in (sys_clk_in),
      .reset_in   (reset_in),
      .async_in   (pins_async),
      .sync_out   (pins_sync)
   );

   assign supplies_ok = &pins_sync[2:0];
   assign select_n    = pins_sync[3];
   assign mode_sync   = pins_sync[6:4];
   assign in_config   = (state != CSS_USER);

   // register writes
   assign config_done = reg_write_in && (reg_addr_in == `CSS_REG_CTRL) && reg_wdata_in[`CSS_CTRL_DONE_BIT];

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         term_setting <= css_term_t'(`CSS_TERM_RESET);
      end else if (reg_write_in && (reg_addr_in == `CSS_REG_CTRL)) begin
         term_setting <= css_term_t'(reg_wdata_in[`CSS_CTRL_TERM_MSB:`CSS_CTRL_TERM_LSB]);
      end
   end

   // register reads, data in the following cycle only
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         reg_rdata_out <= `CSS_READ_ZERO;
      end else if (reg_read_in) begin
         reg_rdata_out <= `CSS_READ_ZERO;
         if (reg_addr_in == `CSS_REG_CTRL) begin
            reg_rdata_out[`CSS_CTRL_TERM_MSB:`CSS_CTRL_TERM_LSB] <= term_setting;
         end else if (reg_addr_in == `CSS_REG_STATUS) begin
            reg_rdata_out[`CSS_STAT_STATE_MSB:`CSS_STAT_STATE_LSB] <= state;
            reg_rdata_out[`CSS_STAT_MODE_MSB:`CSS_STAT_MODE_LSB]   <= config_mode_out;
            reg_rdata_out[`CSS_STAT_INIT_BIT]                      <= init_ready_n_out;
            reg_rdata_out[`CSS_STAT_POWER_BIT]                     <= supplies_ok;
            reg_rdata_out[`CSS_STAT_TERM_MSB:`CSS_STAT_TERM_LSB]   <= unused_pad_termination_out;
         end
      end else begin
         reg_rdata_out <= `CSS_READ_ZERO;
      end
   end

   // sequencing state
   always_comb begin
      next_state = state;
      case (state)
         CSS_POR: begin
            if (supplies_ok) begin
               next_state = CSS_CLEAR;
            end
         end
         CSS_CLEAR: begin
            if (clear_count == CLEAR_LAST) begin
               next_state = CSS_CONFIG;
            end
         end
         CSS_CONFIG: begin
            if (config_done) begin
               next_state = CSS_STARTUP;
            end
         end
         CSS_STARTUP: begin
            next_state = CSS_USER;
         end
         default: begin
            next_state = CSS_USER;
         end
      endcase
      if (!supplies_ok) begin
         next_state = CSS_POR;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         state <= CSS_POR;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in || (state != CSS_CLEAR)) begin
         clear_count <= 8'h00;
      end else begin
         clear_count <= clear_count + 8'h01;
      end
   end

   // global nets, init-ready and the latched mode
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         global_set_reset_net_out <= 1'b1;
      end else begin
         global_set_reset_net_out <= (next_state == CSS_POR) || (next_state == CSS_CLEAR) ||
                                     (next_state == CSS_CONFIG);
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         global_three_state_net_out <= 1'b1;
      end else begin
         global_three_state_net_out <= (next_state != CSS_USER);
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         global_write_enable_net_out <= 1'b0;
      end else begin
         global_write_enable_net_out <= (state == CSS_USER) && (next_state == CSS_USER) &&
                                        !global_three_state_net_out;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         init_ready_n_out <= 1'b0;
      end else begin
         init_ready_n_out <= (next_state == CSS_CONFIG) || (next_state == CSS_STARTUP) ||
                             (next_state == CSS_USER);
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         config_mode_out <= `CSS_MODE_RESET;
      end else if ((state == CSS_CLEAR) && (next_state == CSS_CONFIG)) begin
         config_mode_out <= mode_sync;
      end
   end

   // pin control
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         user_drivers_enable_out    <= 1'b0;
         pullup_enable_out          <= 1'b0;
         dual_pullup_enable_out     <= 8'h00;
         select_pin_weak_pullup_out <= 1'b1;
         select_pin_as_gpio_out     <= 1'b0;
         select_pin_gpio_value_out  <= 1'b0;
         unused_pad_termination_out <= CSS_TERM_FLOAT;
         user_mode_out              <= 1'b0;
      end else begin
         user_drivers_enable_out    <= (next_state == CSS_USER);
         pullup_enable_out          <= (next_state != CSS_USER) && !select_n;
         dual_pullup_enable_out     <= {8{(next_state != CSS_USER) && !select_n}} &
                                       ~dual_used(config_mode_out);
         select_pin_weak_pullup_out <= (next_state != CSS_USER);
         select_pin_as_gpio_out     <= (next_state == CSS_USER);
         select_pin_gpio_value_out  <= (next_state == CSS_USER) && select_n;
         unused_pad_termination_out <= (next_state == CSS_USER) ? term_setting : CSS_TERM_FLOAT;
         user_mode_out              <= (next_state == CSS_USER);
      end
   end

   // checks
   a_pullup_low_select: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (!$past(reset_in) && !select_n && (state != CSS_USER) && $stable(state) && $stable(select_n)) |->
      pullup_enable_out)
      else $error("pull-ups off while select pin low");

   a_pullup_high_select: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (select_n && $stable(select_n)) |-> !pullup_enable_out && (dual_pullup_enable_out == 8'h00))
      else $error("pull-ups on while select pin high");

   a_select_weak_pull: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      in_config |-> select_pin_weak_pullup_out)
      else $error("select pin weak pull-up missing");

   a_por_holds_nets: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      !supplies_ok |=> (state == CSS_POR) && global_set_reset_net_out && !init_ready_n_out &&
                       !global_write_enable_net_out)
      else $error("sequence left power-on reset without supplies");

   a_drivers_hiz: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      global_three_state_net_out |-> !user_drivers_enable_out)
      else $error("drivers active before three-state release");

   a_clear_asserts_gsr: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (state == CSS_CLEAR) |-> global_set_reset_net_out && !init_ready_n_out)
      else $error("set-reset not asserted during clearing");

   a_init_samples_mode: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      $rose(init_ready_n_out) |-> (state == CSS_CONFIG) && (config_mode_out == $past(mode_sync)))
      else $error("mode not sampled at init-ready");

   a_gsr_release: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      $fell(global_set_reset_net_out) |-> (state == CSS_STARTUP) && ($past(state) == CSS_CONFIG))
      else $error("set-reset released outside configuration end");

   a_gts_release: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      $fell(global_three_state_net_out) |-> (state == CSS_USER) && user_drivers_enable_out &&
                                            ($past(state) == CSS_STARTUP))
      else $error("three-state released outside start-up");

   a_unused_term: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      global_three_state_net_out |-> (unused_pad_termination_out == CSS_TERM_FLOAT))
      else $error("unused pad termination before release");

   a_gwe_one_late: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      ($fell(global_three_state_net_out) && supplies_ok) |-> !global_write_enable_net_out ##1
                                                              global_write_enable_net_out)
      else $error("write enable not one cycle after three-state release");

   a_gpio_in_user: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (state == CSS_USER) && $past(state == CSS_USER) |-> select_pin_as_gpio_out && !pullup_enable_out)
      else $error("select pin not released in user mode");

   a_dual_pins: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      ($stable(state) && $stable(select_n) && $stable(config_mode_out)) |->
      (dual_pullup_enable_out == ({8{pullup_enable_out}} & ~dual_used(config_mode_out))))
      else $error("dual-purpose pins differ from user pins");

   a_gwe_held: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      global_three_state_net_out |-> !global_write_enable_net_out)
      else $error("write enable active during configuration");

   c_reach_config: cover property (@(posedge sys_clk_in) disable iff (reset_in)
      $rose(init_ready_n_out));
   c_reach_user: cover property (@(posedge sys_clk_in) disable iff (reset_in)
      $rose(global_write_enable_net_out));
   c_power_drop: cover property (@(posedge sys_clk_in) disable iff (reset_in)
      (state == CSS_USER) ##1 (state == CSS_POR));
   c_pullups_on: cover property (@(posedge sys_clk_in) disable iff (reset_in)
      pullup_enable_out && (state == CSS_CONFIG));
endmodule : css_sequencer

// >>> verification/css_board_model.sv
// board model: supply monitors, mode straps and the pull-up select pin
`timescale 1ns/1ps
module css_board_model (
   input  wire logic       sys_clk_in,
   input  wire logic       power_on_in,
   input  wire logic       bank_enable_in,
   input  wire logic [2:0] mode_in,
   input  wire logic       select_drive_en_in,
   input  wire logic       select_drive_val_in,
   input  wire logic       select_weak_pullup_in,
   output logic            core_good_out,
   output logic            aux_good_out,
   output logic            bank_good_out,
   output logic [2:0]      mode_sel_out,
   output logic            select_pin_out
);
   logic [4:0] ramp = 5'h00;
   logic       last_pin = 1'b1;
   // supplies come up one by one, bank 2 last and only when enabled; all drop together
   always @(posedge sys_clk_in) begin
      if (!power_on_in)
         ramp <= 5'h00;
      else if (ramp != 5'h1F)
         ramp <= ramp + 5'h01;
      last_pin <= select_pin_out;
   end
   assign core_good_out = power_on_in && (ramp >= 5'h03);
   assign aux_good_out  = power_on_in && (ramp >= 5'h07);
   assign bank_good_out = power_on_in && bank_enable_in && (ramp >= 5'h0C);
   assign mode_sel_out  = mode_in;
   // undriven pin: high through the weak pull-up, else it wanders
   assign select_pin_out = select_drive_en_in ? select_drive_val_in :
                           (select_weak_pullup_in ? 1'b1 : ~last_pin);
endmodule : css_board_model

// >>> verification/css_sequencer_tb_top.sv
// self-checking bench for the pin and global net sequencer
`timescale 1ns/1ps
`include "css_cfg.svh"
`define CHK(nm, act, exp) begin total_checks++; if ((act) !== (exp)) begin bad_count++; \
   $display("mismatch %s expected %h seen %h", nm, exp, act); end end
module css_sequencer_tb_top
   import css_pkg::*;
   ;
   logic        sys_clk_in = 1'b0, reset_in = 1'b1, reg_write_in = 1'b0, reg_read_in = 1'b0;
   logic [7:0]  reg_addr_in = 8'h00;
   logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, rd;
   logic        power_on = 1'b0, bank_en = 1'b0, sel_en = 1'b1, sel_val = 1'b1;
   logic [2:0]  strap = 3'h0, m, config_mode_out;
   logic        core_supply_good_in, auxiliary_supply_good_in, bank_output_supply_good_in;
   logic        config_pullup_select_n_in, config_mode_sel_0_in, config_mode_sel_1_in, config_mode_sel_2_in;
   logic        global_set_reset_net_out, global_three_state_net_out, global_write_enable_net_out;
   logic        init_ready_n_out, user_drivers_enable_out, pullup_enable_out, user_mode_out;
   logic        select_pin_weak_pullup_out, select_pin_as_gpio_out, select_pin_gpio_value_out;
   logic [7:0]  dual_pullup_enable_out;
   logic [1:0]  unused_pad_termination_out;
   logic [2:0]  modes [3] = '{3'h7, 3'h2, 3'h5};
   int          bad_count = 0, total_checks = 0, cnt;

   css_board_model board (.sys_clk_in, .power_on_in(power_on), .bank_enable_in(bank_en), .mode_in(strap),
      .select_drive_en_in(sel_en), .select_drive_val_in(sel_val), .select_weak_pullup_in(select_pin_weak_pullup_out),
      .core_good_out(core_supply_good_in), .aux_good_out(auxiliary_supply_good_in),
      .bank_good_out(bank_output_supply_good_in), .select_pin_out(config_pullup_select_n_in),
      .mode_sel_out({config_mode_sel_2_in, config_mode_sel_1_in, config_mode_sel_0_in}));
   css_sequencer dut (.sys_clk_in, .reset_in, .core_supply_good_in, .auxiliary_supply_good_in,
      .bank_output_supply_good_in, .config_pullup_select_n_in, .config_mode_sel_0_in, .config_mode_sel_1_in,
      .config_mode_sel_2_in, .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out,
      .global_set_reset_net_out, .global_three_state_net_out, .global_write_enable_net_out, .init_ready_n_out,
      .config_mode_out, .user_drivers_enable_out, .pullup_enable_out, .dual_pullup_enable_out,
      .select_pin_weak_pullup_out, .select_pin_as_gpio_out, .select_pin_gpio_value_out,
      .unused_pad_termination_out, .user_mode_out);

   initial begin
      forever #5 sys_clk_in = ~sys_clk_in;
   end

   task automatic wait_cycles(input int n);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask : wait_cycles

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_write_in <= 1'b1;
      @(posedge sys_clk_in);
      reg_write_in <= 1'b0;
      #1;
   endtask : reg_write

   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk_in);
      reg_addr_in <= a;
      reg_read_in <= 1'b1;
      @(posedge sys_clk_in);
      reg_read_in <= 1'b0;
      #1;
      d = reg_rdata_out;
   endtask : reg_read

   // pull-ups on dual-purpose pins only where the mode leaves the pin unused
   function automatic logic [7:0] exp_dual(input logic [2:0] md);
      if (md == `CSS_MODE_NO_DUAL)
         return ~`CSS_DUAL_USED_NONE;
      return md[1] ? ~`CSS_DUAL_USED_PAR : ~`CSS_DUAL_USED_SER;
   endfunction : exp_dual

   task automatic bring_up(input logic [2:0] md);
      @(posedge sys_clk_in);
      strap <= md;
      power_on <= 1'b1;
      bank_en <= 1'b1;
      cnt = 0;
      while (bank_output_supply_good_in !== 1'b1 && cnt < 40) begin
         wait_cycles(1);
         cnt++;
      end
      cnt = 0;
      while (init_ready_n_out !== 1'b1 && cnt < 200) begin
         wait_cycles(1);
         cnt++;
      end
      `CHK("clear time", (cnt >= `CSS_CLEAR_CYCLES && cnt <= `CSS_CLEAR_CYCLES + 5), 1'b1)
   endtask : bring_up

   task automatic power_down;
      @(posedge sys_clk_in);
      power_on <= 1'b0;
      bank_en <= 1'b0;
      cnt = 0;
      while (init_ready_n_out !== 1'b0 && cnt < 20) begin
         wait_cycles(1);
         cnt++;
      end
      `CHK("power drop", {global_set_reset_net_out, global_three_state_net_out, global_write_enable_net_out,
         init_ready_n_out, user_drivers_enable_out}, 5'b11000)
   endtask : power_down

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : report_and_stop

   initial begin
      repeat (5000) @(posedge sys_clk_in);
      bad_count++;
      report_and_stop();
   end

   initial begin
      repeat (10) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      #1;
      `CHK("reset outs", {global_set_reset_net_out, global_three_state_net_out, global_write_enable_net_out,
         init_ready_n_out, user_drivers_enable_out, unused_pad_termination_out, select_pin_weak_pullup_out},
         8'b1100_0001)
      reg_read(`CSS_REG_CTRL, rd);
      `CHK("term default", rd[`CSS_CTRL_TERM_MSB:`CSS_CTRL_TERM_LSB], `CSS_TERM_RESET)
      @(posedge sys_clk_in);
      power_on <= 1'b1;
      wait_cycles(80);
      reg_read(`CSS_REG_STATUS, rd);
      `CHK("partial power", {init_ready_n_out, rd[7:0]}, 9'h000)
      $display("test reset and partial power done");
      for (int i = 0; i < 3; i++) begin
         m = modes[i];
         bring_up(m);
         @(posedge sys_clk_in);
         strap <= ~m;
         sel_en <= 1'b1;
         sel_val <= 1'b0;
         wait_cycles(4);
         `CHK("mode latch", config_mode_out, m)
         `CHK("config pullups", {pullup_enable_out, dual_pullup_enable_out}, {1'b1, exp_dual(m)})
         `CHK("config nets", {global_set_reset_net_out, global_three_state_net_out, global_write_enable_net_out,
            user_drivers_enable_out, unused_pad_termination_out}, 6'b110000)
         @(posedge sys_clk_in);
         sel_en <= 1'b0;
         wait_cycles(4);
         `CHK("open select", {pullup_enable_out, dual_pullup_enable_out}, 9'h000)
         if (i < 2)
            power_down();
         $display("test mode %0d done", m);
      end
      reg_write(`CSS_REG_CTRL, 32'h5);
      `CHK("startup", {global_set_reset_net_out, global_three_state_net_out}, 2'b01)
      wait_cycles(1);
      `CHK("user entry", {global_three_state_net_out, user_drivers_enable_out, user_mode_out,
         unused_pad_termination_out, pullup_enable_out, global_write_enable_net_out, select_pin_as_gpio_out},
         8'b0111_0001)
      wait_cycles(1);
      `CHK("write enable", global_write_enable_net_out, 1'b1)
      @(posedge sys_clk_in);
      sel_en <= 1'b1;
      sel_val <= 1'b0;
      wait_cycles(4);
      `CHK("gpio low", {select_pin_weak_pullup_out, select_pin_as_gpio_out, select_pin_gpio_value_out,
         pullup_enable_out, dual_pullup_enable_out}, 12'h400)
      @(posedge sys_clk_in);
      sel_val <= 1'b1;
      wait_cycles(4);
      `CHK("gpio high", select_pin_gpio_value_out, 1'b1)
      reg_read(`CSS_REG_STATUS, rd);
      `CHK("status", rd, {22'h0, 2'h2, 2'b11, 3'h5, CSS_USER})
      reg_write(8'h08, 32'h0);
      reg_read(8'h08, rd);
      `CHK("unmapped", rd, `CSS_READ_ZERO)
      reg_read(`CSS_REG_CTRL, rd);
      `CHK("term kept", rd[`CSS_CTRL_TERM_MSB:`CSS_CTRL_TERM_LSB], 2'h2)
      reg_write(`CSS_REG_CTRL, 32'h0);
      wait_cycles(2);
      `CHK("term float", {unused_pad_termination_out, user_mode_out}, 3'b001)
      $display("test user mode done");
      power_down();
      $display("test power loss done");
      report_and_stop();
   end
endmodule : css_sequencer_tb_top
